// ===== half_bridge_gate_sequencer.sv
`timescale 1ns/1ns
`include "gate_seq_cfg.svh"
module half_bridge_gate_sequencer import gate_seq_pkg::*; #(
	parameter int PHASES = 3,
	parameter bit HW_VARIANT = 1'b0
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic serial_select_n,
	input wire logic serial_clock,
	output logic serial_data_out,
	output logic serial_data_oe,
	input wire logic [1:0] strap_gain,
	input wire logic [2:0] strap_current,
	input wire logic [1:0] strap_scheme,
	input wire logic [2:0] drain_source_threshold_strap,
	input wire logic [PHASES-1:0] cmd_high,
	input wire logic [PHASES-1:0] cmd_low,
	input wire logic [PHASES-1:0] vgs_high_on,
	input wire logic [PHASES-1:0] vgs_low_on,
	input wire logic supply_uv,
	output wire logic [PHASES-1:0] gate_high_on,
	output wire logic [PHASES-1:0] gate_low_on,
	output wire logic [PHASES-1:0] gate_high_strong,
	output wire logic [PHASES-1:0] gate_low_strong,
	output wire logic [PHASES-1:0] pulldown_high,
	output wire logic [PHASES-1:0] pulldown_low,
	output logic [3:0] gate_current_select,
	output logic [1:0] amp_gain_select,
	output logic [2:0] ds_threshold_select,
	output logic fault_flag_out_n
);

	localparam int WIN_W = 6;

	if (PHASES < 1 || PHASES > 3) begin : g_chk_phases
		$error("PHASES must be 1 to 3");
	end
	if (`WIN_HW_CYC >= (1 << WIN_W) || `WIN3_CYC >= (1 << WIN_W)) begin : g_chk_win
		$error("window counter too narrow");
	end

	// ==========================================
	// helpers
	function automatic logic [1:0] scheme_decode(input logic [1:0] sch, input logic h,
			input logic l);
		logic [1:0] r;
		r = 2'h0;
		case (sch)
			SCHEME_THREE: r = {l & h, l & ~h};
			SCHEME_INDEP: r = {h, l};
			default: r = {h & ~l, l & ~h};
		endcase
		return r;
	endfunction

	function automatic logic [3:0] strap_to_current(input logic [2:0] k);
		logic [3:0] r;
		r = 4'hF;
		case (k)
			3'h0: r = 4'h0;
			3'h1: r = 4'h2;
			3'h2: r = 4'h4;
			3'h3: r = 4'h7;
			3'h4: r = 4'h9;
			3'h5: r = 4'hC;
			default: r = 4'hF;
		endcase
		return r;
	endfunction

	function automatic logic [WIN_W-1:0] win_len(input logic [1:0] sel);
		logic [WIN_W-1:0] r;
		r = WIN_W'(`WIN3_CYC);
		case (sel)
			2'h0: r = WIN_W'(`WIN0_CYC);
			2'h1: r = WIN_W'(`WIN1_CYC);
			2'h2: r = WIN_W'(`WIN2_CYC);
			default: r = WIN_W'(`WIN3_CYC);
		endcase
		return r;
	endfunction

	function automatic logic [2:0] gap_len(input logic [1:0] sel);
		logic [2:0] r;
		r = 3'h0;
		case (sel)
			2'h1: r = 3'(`GAP1_CYC);
			2'h2: r = 3'(`GAP2_CYC);
			2'h3: r = 3'(`GAP3_CYC);
			default: r = 3'h0;
		endcase
		return r;
	endfunction

	// ==========================================
	// control and status registers
	logic [15:0] ctrl;
	logic [2*PHASES-1:0] gate_fault;
	logic uv_sticky;
	wire logic [2*PHASES-1:0] fault_evt;
	logic sel_ok;
	logic [15:0] rd_val;
	logic [15:0] status_val;

	assign sel_ok = ~serial_select_n & ~HW_VARIANT;

	always_comb begin
		status_val = 16'h0000;
		status_val[`STAT_GATE_LSB +: 2*PHASES] = gate_fault;
		status_val[`STAT_UV_BIT] = uv_sticky;
		status_val[`STAT_UV_LIVE_BIT] = supply_uv;
		case (reg_addr)
			`REG_CTRL: rd_val = ctrl;
			`REG_STATUS: rd_val = status_val;
			default: rd_val = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl <= `CTRL_RST;
		end else if (sel_ok && reg_wr && reg_addr == `REG_CTRL) begin
			ctrl <= reg_wdata;
		end
	end

	// hardware sets win over a write-one clear
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			gate_fault <= '0;
			uv_sticky <= 1'b0;
		end else begin
			for (int i = 0; i < 2*PHASES; i++) begin
				if (fault_evt[i]) begin
					gate_fault[i] <= 1'b1;
				end else if (sel_ok && reg_wr && reg_addr == `REG_STATUS &&
						reg_wdata[`STAT_GATE_LSB + i]) begin
					gate_fault[i] <= 1'b0;
				end
			end
			if (supply_uv) begin
				uv_sticky <= 1'b1;
			end else if (sel_ok && reg_wr && reg_addr == `REG_STATUS &&
					reg_wdata[`STAT_UV_BIT]) begin
				uv_sticky <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
		end else if (sel_ok && reg_rd) begin
			reg_rdata <= rd_val;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ==========================================
	// serial read-back shifter, open drain
	logic [15:0] shift;
	logic sclk_q;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			shift <= 16'hFFFF;
			sclk_q <= 1'b0;
			serial_data_out <= 1'b0;
			serial_data_oe <= 1'b0;
		end else begin
			sclk_q <= serial_clock;
			if (sel_ok && reg_rd) begin
				shift <= rd_val;
			end else if (sel_ok && serial_clock && !sclk_q) begin
				shift <= {shift[14:0], 1'b1};
			end
			serial_data_out <= 1'b0;
			serial_data_oe <= sel_ok & ~shift[15];
		end
	end

	// ==========================================
	// effective settings
	logic [1:0] scheme;
	logic [WIN_W-1:0] win_cyc;
	logic [2:0] gap_cyc;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			scheme <= SCHEME_SIX;
			win_cyc <= WIN_W'(`WIN_HW_CYC);
			gap_cyc <= 3'h0;
			gate_current_select <= 4'h0;
			amp_gain_select <= 2'h0;
			ds_threshold_select <= 3'h0;
		end else if (HW_VARIANT) begin
			scheme <= strap_scheme;
			win_cyc <= WIN_W'(`WIN_HW_CYC);
			gap_cyc <= 3'h0;
			gate_current_select <= strap_to_current(strap_current);
			amp_gain_select <= strap_gain;
			ds_threshold_select <= drain_source_threshold_strap;
		end else begin
			scheme <= ctrl[`CTRL_SCHEME_LSB +: 2];
			win_cyc <= win_len(ctrl[`CTRL_WIN_LSB +: 2]);
			gap_cyc <= gap_len(ctrl[`CTRL_GAP_LSB +: 2]);
			gate_current_select <= ctrl[`CTRL_CUR_LSB +: 4];
			amp_gain_select <= ctrl[`CTRL_GAIN_LSB +: 2];
			ds_threshold_select <= ctrl[`CTRL_THR_LSB +: 3];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			fault_flag_out_n <= 1'b1;
		end else begin
			fault_flag_out_n <= ~(|gate_fault | uv_sticky | supply_uv);
		end
	end

	// ==========================================
	// command deglitch and delay stage
	logic [2*PHASES-1:0] cmd_s1;
	logic [2*PHASES-1:0] cmd_s2;
	logic [2*PHASES-1:0] cmd_filt;
	logic [2*PHASES-1:0] cmd_dly;
	logic [2*PHASES-1:0] cmd_prev;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cmd_s1 <= '0;
			cmd_s2 <= '0;
			cmd_filt <= '0;
			cmd_dly <= '0;
			cmd_prev <= '0;
		end else begin
			cmd_s1 <= {cmd_high, cmd_low};
			cmd_s2 <= cmd_s1;
			for (int i = 0; i < 2*PHASES; i++) begin
				if (cmd_s1[i] == cmd_s2[i]) begin
					cmd_filt[i] <= cmd_s1[i];
				end
			end
			cmd_dly <= cmd_filt;
			cmd_prev <= cmd_dly;
		end
	end

	// ==========================================
	// per phase gate sequencer
	for (genvar p = 0; p < PHASES; p++) begin : g_ph
		gate_state_e st;
		gate_state_e next_st;
		logic gh;
		logic gl;
		logic next_gh;
		logic next_gl;
		logic on_high;
		logic next_on_high;
		logic [2:0] gap;
		logic [2:0] next_gap;
		logic [WIN_W-1:0] win;
		logic sw_high;
		logic sw_on;
		logic load;
		logic load_high;
		logic load_on;
		logic dh;
		logic dl;
		logic want_on;
		logic changed;
		logic hs;
		logic ls;
		logic pdh;
		logic pdl;

		assign {dh, dl} = supply_uv ? 2'h0 :
			scheme_decode(scheme, cmd_dly[PHASES + p], cmd_dly[p]);
		assign changed = (cmd_dly[PHASES + p] != cmd_prev[PHASES + p]) ||
			(cmd_dly[p] != cmd_prev[p]);
		assign want_on = on_high ? dh : dl;

		always_comb begin
			next_st = st;
			next_gh = gh;
			next_gl = gl;
			next_on_high = on_high;
			next_gap = gap;
			load = 1'b0;
			load_high = 1'b0;
			load_on = 1'b0;
			case (st)
				S_HOLD: begin
					if (gh && !dh) begin
						next_gh = 1'b0;
						load = 1'b1;
						load_high = 1'b1;
					end else if (gl && !dl) begin
						next_gl = 1'b0;
						load = 1'b1;
					end else if (!gh && dh) begin
						if (scheme == SCHEME_INDEP) begin
							next_gh = 1'b1;
							load = 1'b1;
							load_high = 1'b1;
							load_on = 1'b1;
						end else begin
							next_on_high = 1'b1;
							next_st = S_WAIT_OFF;
						end
					end else if (!gl && dl) begin
						if (scheme == SCHEME_INDEP) begin
							next_gl = 1'b1;
							load = 1'b1;
							load_on = 1'b1;
						end else begin
							next_on_high = 1'b0;
							next_st = S_WAIT_OFF;
						end
					end
				end
				S_WAIT_OFF: begin
					if (!want_on) begin
						next_st = S_HOLD;
					end else if (!(on_high ? vgs_low_on[p] : vgs_high_on[p])) begin
						next_gap = gap_cyc;
						next_st = S_GAP;
					end
				end
				S_GAP: begin
					if (!want_on) begin
						next_st = S_HOLD;
					end else if (gap == 3'h0) begin
						next_gh = on_high ? 1'b1 : gh;
						next_gl = on_high ? gl : 1'b1;
						load = 1'b1;
						load_high = on_high;
						load_on = 1'b1;
						next_st = S_HOLD;
					end else begin
						next_gap = gap - 3'h1;
					end
				end
				default: next_st = S_HOLD;
			endcase
		end

		always_ff @(posedge clk_sys) begin
			if (!nrst) begin
				st <= S_HOLD;
				gh <= 1'b0;
				gl <= 1'b0;
				on_high <= 1'b0;
				gap <= 3'h0;
			end else begin
				st <= next_st;
				gh <= next_gh;
				gl <= next_gl;
				on_high <= next_on_high;
				gap <= next_gap;
			end
		end

		always_ff @(posedge clk_sys) begin
			if (!nrst) begin
				win <= '0;
				sw_high <= 1'b0;
				sw_on <= 1'b0;
			end else if (load) begin
				win <= win_cyc;
				sw_high <= load_high;
				sw_on <= load_on;
			end else if (changed) begin
				win <= '0;
			end else if (win != '0) begin
				win <= win - WIN_W'(1);
			end
		end

		// strong drive and opposite pulldown stand exactly while the window runs
		always_ff @(posedge clk_sys) begin
			if (!nrst) begin
				hs <= 1'b0;
				ls <= 1'b0;
				pdh <= 1'b0;
				pdl <= 1'b0;
			end else if (load) begin
				hs <= load_high;
				ls <= ~load_high;
				pdh <= ~load_high;
				pdl <= load_high;
			end else if (changed || win <= WIN_W'(1)) begin
				hs <= 1'b0;
				ls <= 1'b0;
				pdh <= 1'b0;
				pdl <= 1'b0;
			end
		end

		assign fault_evt[2*p + 1] = !load && !changed && win == WIN_W'(1) && sw_high &&
			(vgs_high_on[p] != sw_on);
		assign fault_evt[2*p] = !load && !changed && win == WIN_W'(1) && !sw_high &&
			(vgs_low_on[p] != sw_on);

		assign gate_high_on[p] = gh;
		assign gate_low_on[p] = gl;
		assign gate_high_strong[p] = hs;
		assign gate_low_strong[p] = ls;
		assign pulldown_high[p] = pdh;
		assign pulldown_low[p] = pdl;
	end

endmodule

// ===== gate_seq_cfg.svh
`ifndef GATE_SEQ_CFG_SVH
`define GATE_SEQ_CFG_SVH

// ==========================================
// register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04

// ==========================================
// control field positions
`define CTRL_CUR_LSB 0
`define CTRL_SCHEME_LSB 4
`define CTRL_WIN_LSB 6
`define CTRL_GAP_LSB 8
`define CTRL_GAIN_LSB 10
`define CTRL_THR_LSB 12
`define CTRL_RST 16'h00CF

// ==========================================
// status field positions
`define STAT_GATE_LSB 0
`define STAT_UV_BIT 6
`define STAT_UV_LIVE_BIT 7

// ==========================================
// timing
`define CLK_NS 100
`define WIN_HW_NS 4000
`define WIN0_NS 500
`define WIN1_NS 1000
`define WIN2_NS 2000
`define WIN3_NS 4000
`define GAP1_NS 100
`define GAP2_NS 200
`define GAP3_NS 400
`define WIN_HW_CYC (`WIN_HW_NS / `CLK_NS)
`define WIN0_CYC (`WIN0_NS / `CLK_NS)
`define WIN1_CYC (`WIN1_NS / `CLK_NS)
`define WIN2_CYC (`WIN2_NS / `CLK_NS)
`define WIN3_CYC (`WIN3_NS / `CLK_NS)
`define GAP1_CYC ((`GAP1_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP2_CYC ((`GAP2_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP3_CYC ((`GAP3_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== gate_seq_pkg.sv
package gate_seq_pkg;

	typedef enum logic [1:0] {
		SCHEME_SIX = 2'h0,
		SCHEME_THREE = 2'h1,
		SCHEME_ONE = 2'h2,
		SCHEME_INDEP = 2'h3
	} cmd_scheme_e;

	typedef enum logic [1:0] {
		S_HOLD = 2'h0,
		S_WAIT_OFF = 2'h1,
		S_GAP = 2'h3
	} gate_state_e;

endpackage

// ===== gate_stage_model.sv
`timescale 1ns/1ns
module gate_stage_model #(
	parameter int PHASES = 3
) (
	input wire logic clk_sys,
	input wire logic [PHASES-1:0] gate_high_on,
	input wire logic [PHASES-1:0] gate_low_on,
	input wire logic [PHASES-1:0] stuck_off,
	output logic [PHASES-1:0] vgs_high_on,
	output logic [PHASES-1:0] vgs_low_on
);
	logic [PHASES-1:0] hd;
	logic [PHASES-1:0] ld;
	// gates settle in two cycles, well inside the shortest window
	always_ff @(posedge clk_sys) begin
		hd <= gate_high_on;
		ld <= gate_low_on;
		vgs_high_on <= hd & ~stuck_off;
		vgs_low_on <= ld;
	end
endmodule

// ===== half_bridge_gate_sequencer_chk.sv
`timescale 1ns/1ns
module gate_seq_chk #(
	parameter int PHASES = 3
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic serial_select_n,
	input wire logic serial_data_out,
	input wire logic serial_data_oe,
	input wire logic [PHASES-1:0] vgs_low_on,
	input wire logic supply_uv,
	input wire logic [PHASES-1:0] gate_high_on,
	input wire logic [PHASES-1:0] gate_low_on,
	input wire logic [PHASES-1:0] gate_high_strong,
	input wire logic [PHASES-1:0] pulldown_low,
	input wire logic [PHASES-1:0] gate_low_strong,
	input wire logic [PHASES-1:0] pulldown_high,
	input wire logic [3:0] gate_current_select,
	input wire logic [1:0] amp_gain_select,
	input wire logic [2:0] ds_threshold_select,
	input wire logic fault_flag_out_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	logic [7:0] run;
	logic hon_q;
	// ==========
	// strong drive length since the last gate change, phase 0
	always_ff @(posedge clk_sys) begin
		hon_q <= gate_high_on[0];
		if (!nrst || !gate_high_strong[0] || gate_high_on[0] != hon_q) begin
			run <= 8'h00;
		end else begin
			run <= run + 8'h01;
		end
	end
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not cleared");
	AST_SEL_OFF: assert property (reg_rd && serial_select_n |=> reg_rdata == 16'h0000)
		else $error("read answered while deselected");
	AST_OD_LOW: assert property (serial_data_out == 1'b0)
		else $error("serial data driven high");
	AST_OE_SEL: assert property ($past(serial_select_n) |-> !serial_data_oe)
		else $error("serial data pulled while deselected");
	AST_CTRL_LOAD: assert property (reg_wr && !serial_select_n && reg_addr == 8'h00 |->
		##2 gate_current_select == $past(reg_wdata[3:0], 2)
		&& amp_gain_select == $past(reg_wdata[11:10], 2)
		&& ds_threshold_select == $past(reg_wdata[14:12], 2))
		else $error("settings not loaded");
	AST_DEAD: assert property ($rose(gate_high_on[0]) |-> !gate_low_on[0] && !vgs_low_on[0])
		else $error("high on before low off");
	AST_PULLDOWN: assert property (gate_high_strong[0] |-> pulldown_low[0])
		else $error("opposite pulldown missing");
	AST_PULLDOWN_HI: assert property (gate_low_strong[0] |-> pulldown_high[0])
		else $error("high gate pulldown missing");
	AST_ON_STRONG: assert property ($rose(gate_high_on[0]) |-> gate_high_strong[0])
		else $error("turn-on without strong drive");
	AST_WIN_MAX: assert property (run <= 8'h28)
		else $error("strong drive too long");
	AST_UV_FLAG: assert property (supply_uv |-> ##[1:2] !fault_flag_out_n)
		else $error("undervoltage not flagged");
	AST_UV_OFF: assert property (supply_uv [*2] |-> ##[0:8] (gate_high_on == '0 && gate_low_on == '0))
		else $error("gates on during undervoltage");
	cover property ($fell(gate_high_strong[0]));
	cover property (!fault_flag_out_n);
	cover property (serial_data_oe);
endmodule
bind half_bridge_gate_sequencer gate_seq_chk #(.PHASES(PHASES)) chk_u (.clk_sys(clk_sys),
	.nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .serial_select_n(serial_select_n), .serial_data_out(serial_data_out),
	.serial_data_oe(serial_data_oe), .vgs_low_on(vgs_low_on), .supply_uv(supply_uv),
	.gate_high_on(gate_high_on), .gate_low_on(gate_low_on), .gate_high_strong(gate_high_strong),
	.pulldown_low(pulldown_low), .gate_low_strong(gate_low_strong),
	.pulldown_high(pulldown_high), .gate_current_select(gate_current_select),
	.amp_gain_select(amp_gain_select), .ds_threshold_select(ds_threshold_select),
	.fault_flag_out_n(fault_flag_out_n));

// ===== half_bridge_gate_sequencer_test.sv
`timescale 1ns/1ns
`include "gate_seq_cfg.svh"
module half_bridge_gate_sequencer_test;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic serial_select_n = 1'b1;
	logic serial_clock = 1'b0;
	logic [2:0] cmd_high = 3'h0;
	logic [2:0] cmd_low = 3'h0;
	logic [2:0] stuck_off = 3'h0;
	logic supply_uv = 1'b0;
	logic [15:0] reg_rdata;
	logic serial_data_oe;
	logic [2:0] vgs_high_on;
	logic [2:0] vgs_low_on;
	logic [2:0] gate_high_on;
	logic [2:0] gate_low_on;
	logic [2:0] gate_high_strong;
	logic [3:0] gate_current_select;
	logic fault_flag_out_n;
	logic [2:0] strap_cur = 3'h0;
	logic [3:0] hw_cur;
	logic [2:0] hw_thr;
	logic [31:0] seed = 32'hCE852684;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	always #50 clk_sys = ~clk_sys;
	half_bridge_gate_sequencer dut_u (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.serial_select_n(serial_select_n), .serial_clock(serial_clock), .serial_data_out(),
		.serial_data_oe(serial_data_oe), .strap_gain(2'h0), .strap_current(3'h0),
		.strap_scheme(2'h0), .drain_source_threshold_strap(3'h0), .cmd_high(cmd_high),
		.cmd_low(cmd_low), .vgs_high_on(vgs_high_on), .vgs_low_on(vgs_low_on),
		.supply_uv(supply_uv), .gate_high_on(gate_high_on), .gate_low_on(gate_low_on),
		.gate_high_strong(gate_high_strong), .gate_low_strong(), .pulldown_high(),
		.pulldown_low(), .gate_current_select(gate_current_select), .amp_gain_select(),
		.ds_threshold_select(), .fault_flag_out_n(fault_flag_out_n));
	half_bridge_gate_sequencer #(.HW_VARIANT(1'b1)) dut_hw_u (.clk_sys(clk_sys), .nrst(nrst),
		.reg_addr(8'h00), .reg_wdata(16'h0000), .reg_wr(1'b0), .reg_rd(1'b0), .reg_rdata(),
		.serial_select_n(1'b1), .serial_clock(1'b0), .serial_data_out(), .serial_data_oe(),
		.strap_gain(2'h1), .strap_current(strap_cur), .strap_scheme(2'h0),
		.drain_source_threshold_strap(strap_cur), .cmd_high(3'h0), .cmd_low(3'h0),
		.vgs_high_on(3'h0), .vgs_low_on(3'h0), .supply_uv(1'b0), .gate_high_on(),
		.gate_low_on(), .gate_high_strong(), .gate_low_strong(), .pulldown_high(),
		.pulldown_low(), .gate_current_select(hw_cur), .amp_gain_select(),
		.ds_threshold_select(hw_thr), .fault_flag_out_n());
	gate_stage_model #(.PHASES(3)) stage_u (.clk_sys(clk_sys), .gate_high_on(gate_high_on),
		.gate_low_on(gate_low_on), .stuck_off(stuck_off), .vgs_high_on(vgs_high_on),
		.vgs_low_on(vgs_low_on));
	// ==========
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] r;
		r = v ^ (v << 13);
		r = r ^ (r >> 17);
		return r ^ (r << 5);
	endfunction
	function automatic logic [15:0] win_cyc(input logic [1:0] sel);
		return (sel == 2'h0) ? `WIN0_CYC : (sel == 2'h1) ? `WIN1_CYC :
			(sel == 2'h2) ? `WIN2_CYC : `WIN3_CYC;
	endfunction
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	// ==========
	// main sequence
	initial begin
		logic [15:0] d;
		logic [15:0] cfg;
		logic ok;
		int w;
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		serial_select_n <= 1'b0;
		@(posedge clk_sys);
		rd(8'h00, d);
		chk("ctrl_reset", 16'h00CF, d);
		seed = xs(seed);
		cfg = {1'b0, seed[14:8], 4'h0, seed[3:0]};
		wr(8'h00, cfg);
		rd(8'h00, d);
		chk("ctrl", cfg, d);
		chk("current", {12'h000, cfg[3:0]}, {12'h000, gate_current_select});
		rd(8'h08, d);
		chk("unmapped", 16'h0000, d);
		strap_cur <= 3'h3;
		repeat (3) @(posedge clk_sys);
		chk("hw_current", 16'h0007, {12'h000, hw_cur});
		chk("hw_threshold", 16'h0003, {13'h0000, hw_thr});
		serial_select_n <= 1'b1;
		wr(8'h00, 16'h00CF);
		rd(8'h00, d);
		chk("deselected", 16'h0000, d);
		serial_select_n <= 1'b0;
		rd(8'h00, d);
		@(posedge clk_sys);
		chk("sdo_msb", {15'h0000, ~cfg[15]}, {15'h0000, serial_data_oe});
		serial_clock <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("sdo_next", {15'h0000, ~cfg[14]}, {15'h0000, serial_data_oe});
		serial_clock <= 1'b0;
		cmd_low <= 3'h7;
		repeat (20) @(posedge clk_sys);
		chk("low_on", 16'h0007, {13'h0000, gate_low_on});
		ok = 1'b1;
		cmd_low <= 3'h6;
		@(posedge clk_sys);
		cmd_low <= 3'h7;
		repeat (8) begin
			@(posedge clk_sys);
			ok = ok & (gate_low_on[0] === 1'b1);
		end
		chk("glitch", 16'h0001, {15'h0000, ok});
		cmd_low <= 3'h0;
		cmd_high <= 3'h1;
		w = 0;
		while (gate_high_on[0] !== 1'b1 && w < 50) begin
			@(posedge clk_sys);
			w++;
		end
		chk("high_on", 16'h0001, {15'h0000, gate_high_on[0]});
		w = 0;
		while (gate_high_strong[0] === 1'b1 && w < 50) begin
			@(posedge clk_sys);
			w++;
		end
		chk("window", win_cyc(2'h0), 16'(w));
		wr(8'h00, cfg | 16'h00C0);
		repeat (60) begin
			seed = xs(seed);
			cmd_high <= seed[2:0];
			cmd_low <= seed[5:3] & ~seed[2:0];
			repeat (seed[10:8] + 2) @(posedge clk_sys);
		end
		cmd_high <= 3'h0;
		cmd_low <= 3'h0;
		repeat (60) @(posedge clk_sys);
		wr(8'h04, 16'hFFFF);
		stuck_off <= 3'h2;
		cmd_high <= 3'h2;
		repeat (60) @(posedge clk_sys);
		chk("fault_pin", 16'h0000, {15'h0000, fault_flag_out_n});
		rd(8'h04, d);
		chk("status_gate", 16'h0008, d);
		cmd_high <= 3'h0;
		stuck_off <= 3'h0;
		repeat (20) @(posedge clk_sys);
		wr(8'h04, 16'hFFFF);
		rd(8'h04, d);
		chk("status_clear", 16'h0000, d);
		supply_uv <= 1'b1;
		repeat (3) @(posedge clk_sys);
		supply_uv <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd(8'h04, d);
		chk("status_uv", 16'h0040, d);
		summarize();
	end
endmodule
